// ===== hpmr_master.sv
`default_nettype none
module hpmr_master (
  // clock
  input wire logic mclk,
  // request
  output logic req_valid,
  output logic [15:0] req_addr,
  output logic [7:0] req_count,
  input wire logic req_ready,
  // answer
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic rsp_exc,
  input wire logic rsp_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] q [$];
  logic exc = 1'b0;
  logic dn = 1'b0;
  initial {req_valid, req_addr, req_count} = 25'h0;
  always @(posedge mclk) begin
    if (rsp_valid === 1'b1) q.push_back(rsp_data);
    if (rsp_exc === 1'b1) exc = 1'b1;
    if (rsp_done === 1'b1) dn = 1'b1;
  end
  // both halves in one request, so they cannot mix two updates
  task automatic rd(input logic [15:0] a, input logic [7:0] n);
    q.delete();
    exc = 1'b0;
    dn = 1'b0;
    while (req_ready !== 1'b1) @(negedge mclk);
    {req_valid, req_addr, req_count} = {1'b1, a, n};
    @(negedge mclk);
    // released lines show the inverse, never the stale request
    {req_valid, req_addr, req_count} = {1'b0, ~a, ~n};
    for (int t = 0; t < 40 && dn !== 1'b1; t++) @(negedge mclk);
  endtask
endmodule
`default_nettype wire

// ===== hpmr_pkg.sv
`default_nettype none

package hpmr_pkg;

  // ------------------------------------------------------------
  // map geometry
  // ------------------------------------------------------------
  localparam int NUM_QTY = 19;
  localparam int IDX_W = 5;
  localparam int ADDR_W = 16;
  localparam int WORD_W = 16;
  localparam int PAIR_W = 32;
  localparam logic [15:0] REG_NUM_BASE = 16'h0001;

  // ------------------------------------------------------------
  // not-available patterns
  // ------------------------------------------------------------
  localparam logic [31:0] FLOAT_NA = 32'h7FC00000;
  localparam logic [15:0] INT_NA = 16'h8000;

  // ------------------------------------------------------------
  // quantity table, same index order in both formats:
  // rh, temp, dewpt, dew_frost, dew_frost_1atm, dewpt_1atm, abs_hum,
  // mix_ratio, wet_bulb, h2o_conc, vapour_press, sat_press, enthalpy,
  // water_act, dewpt_diff, abs_hum_ntp, h2o_in_oil, rel_sat, mass_frac
  // ------------------------------------------------------------
  localparam logic [15:0] FLT_ADDR [NUM_QTY] = '{
    16'h0000, 16'h0002, 16'h0006, 16'h0008, 16'h000A, 16'h000C, 16'h000E,
    16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001A, 16'h001C,
    16'h001E, 16'h0020, 16'h0022, 16'h0028, 16'h0040
  };
  localparam logic [15:0] INT_ADDR [NUM_QTY] = '{
    16'h0100, 16'h0101, 16'h0103, 16'h0104, 16'h0105, 16'h0106, 16'h0107,
    16'h0108, 16'h0109, 16'h010A, 16'h010B, 16'h010C, 16'h010D, 16'h010E,
    16'h010F, 16'h0110, 16'h0111, 16'h0114, 16'h0120
  };
  // scale that the producer has already applied to each integer word
  localparam int INT_SCALE [NUM_QTY] = '{
    100, 100, 100, 100, 100, 100, 100, 100, 100, 1,
    10, 10, 100, 10000, 10, 100, 1, 100, 1
  };

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {HPMR_IDLE, HPMR_CHECK, HPMR_SEND} hpmr_state_t;

  typedef struct packed {
    logic hit;
    logic is_flt;
    logic hi;
    logic [IDX_W-1:0] idx;
  } hpmr_dec_t;

  function automatic logic [15:0] hpmr_reg_to_addr(input logic [15:0] reg_num);
    return reg_num - REG_NUM_BASE;
  endfunction

endpackage

`default_nettype wire

// ===== hpmr_regs.sv

`default_nettype none

module hpmr_regs
  import hpmr_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RSTN,
  // live measurements, one lane per quantity in table order
  input wire logic [NUM_QTY*PAIR_W-1:0] MEAS_FLT,
  input wire logic [NUM_QTY*WORD_W-1:0] MEAS_INT,
  input wire logic [NUM_QTY-1:0] MEAS_VALID,
  // read request from the protocol engine
  input wire logic REQ_VALID,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic [CNT_W-1:0] REQ_COUNT,
  output logic REQ_READY,
  // read answer
  output logic RSP_VALID,
  output logic [WORD_W-1:0] RSP_DATA,
  output logic RSP_EXC,
  output logic RSP_DONE
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    hpmr_state_t st;
    logic [ADDR_W-1:0] start;
    logic [ADDR_W-1:0] cur;
    logic [CNT_W-1:0] total;
    logic [CNT_W-1:0] left;
    logic [NUM_QTY-1:0][PAIR_W-1:0] snap_flt;
    logic [NUM_QTY-1:0][WORD_W-1:0] snap_int;
    logic [NUM_QTY-1:0] snap_ok;
    logic rsp_valid;
    logic [WORD_W-1:0] rsp_data;
    logic rsp_exc;
    logic rsp_done;
  } hpmr_regs_t;

  hpmr_regs_t r;
  hpmr_regs_t next_r;
  hpmr_dec_t dec;
  logic [PAIR_W-1:0] pair;

  // ------------------------------------------------------------
  // quantity slots
  // ------------------------------------------------------------
  // one slot per quantity, shared by its float pair and its integer word
  localparam logic [IDX_W-1:0] Q_RH = 5'h00;
  localparam logic [IDX_W-1:0] Q_TEMP = 5'h01;
  localparam logic [IDX_W-1:0] Q_DEWPT = 5'h02;
  localparam logic [IDX_W-1:0] Q_DEW_FROST = 5'h03;
  localparam logic [IDX_W-1:0] Q_DEW_FROST_1ATM = 5'h04;
  localparam logic [IDX_W-1:0] Q_DEWPT_1ATM = 5'h05;
  localparam logic [IDX_W-1:0] Q_ABS_HUM = 5'h06;
  localparam logic [IDX_W-1:0] Q_MIX_RATIO = 5'h07;
  localparam logic [IDX_W-1:0] Q_WET_BULB = 5'h08;
  localparam logic [IDX_W-1:0] Q_H2O_CONC = 5'h09;
  localparam logic [IDX_W-1:0] Q_VAPOUR_PRESS = 5'h0A;
  localparam logic [IDX_W-1:0] Q_SAT_PRESS = 5'h0B;
  localparam logic [IDX_W-1:0] Q_ENTHALPY = 5'h0C;
  localparam logic [IDX_W-1:0] Q_WATER_ACT = 5'h0D;
  localparam logic [IDX_W-1:0] Q_DEWPT_DIFF = 5'h0E;
  localparam logic [IDX_W-1:0] Q_ABS_HUM_NTP = 5'h0F;
  localparam logic [IDX_W-1:0] Q_H2O_IN_OIL = 5'h10;
  localparam logic [IDX_W-1:0] Q_REL_SAT = 5'h11;
  localparam logic [IDX_W-1:0] Q_MASS_FRAC = 5'h12;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  // a float pair owns its even address and the odd one above it
  function automatic hpmr_dec_t hpmr_flt_slot(input logic [ADDR_W-1:0] a);
    hpmr_dec_t d;
    d = '0;
    d.is_flt = 1'b1;
    d.hi = a[0];
    unique case (a[ADDR_W-1:1])
      FLT_ADDR[Q_RH][ADDR_W-1:1]: begin
        d.hit = 1'b1;
        d.idx = Q_RH;
      end
      FLT_ADDR[Q_TEMP][ADDR_W-1:1]: begin
        d.hit = 1'b1;
        d.idx = Q_TEMP;
      end
      FLT_ADDR[Q_DEWPT][ADDR_W-1:1]: begin
        d.hit = 1'b1;
        d.idx = Q_DEWPT;
      end
      FLT_ADDR[Q_DEW_FROST][ADDR_W-1:1]: begin
        d.hit = 1'b1;
        d.idx = Q_DEW_FROST;
      end
      FLT_ADDR[Q_DEW_FROST_1ATM][ADDR_W-1:1]: begin
        d.hit = 1'b1;
        d.idx = Q_DEW_FROST_1ATM;
      end
      FLT_ADDR[Q_DEWPT_1ATM][ADDR_W-1:1]: begin
        d.hit = 1'b1;
        d.idx = Q_DEWPT_1ATM;
      end
      FLT_ADDR[Q_ABS_HUM][ADDR_W-1:1]: begin
        d.hit = 1'b1;
        d.idx = Q_ABS_HUM;
      end
      FLT_ADDR[Q_MIX_RATIO][ADDR_W-1:1]: begin
        d.hit = 1'b1;
        d.idx = Q_MIX_RATIO;
      end
      FLT_ADDR[Q_WET_BULB][ADDR_W-1:1]: begin
        d.hit = 1'b1;
        d.idx = Q_WET_BULB;
      end
      FLT_ADDR[Q_H2O_CONC][ADDR_W-1:1]: begin
        d.hit = 1'b1;
        d.idx = Q_H2O_CONC;
      end
      FLT_ADDR[Q_VAPOUR_PRESS][ADDR_W-1:1]: begin
        d.hit = 1'b1;
        d.idx = Q_VAPOUR_PRESS;
      end
      FLT_ADDR[Q_SAT_PRESS][ADDR_W-1:1]: begin
        d.hit = 1'b1;
        d.idx = Q_SAT_PRESS;
      end
      FLT_ADDR[Q_ENTHALPY][ADDR_W-1:1]: begin
        d.hit = 1'b1;
        d.idx = Q_ENTHALPY;
      end
      FLT_ADDR[Q_WATER_ACT][ADDR_W-1:1]: begin
        d.hit = 1'b1;
        d.idx = Q_WATER_ACT;
      end
      FLT_ADDR[Q_DEWPT_DIFF][ADDR_W-1:1]: begin
        d.hit = 1'b1;
        d.idx = Q_DEWPT_DIFF;
      end
      FLT_ADDR[Q_ABS_HUM_NTP][ADDR_W-1:1]: begin
        d.hit = 1'b1;
        d.idx = Q_ABS_HUM_NTP;
      end
      FLT_ADDR[Q_H2O_IN_OIL][ADDR_W-1:1]: begin
        d.hit = 1'b1;
        d.idx = Q_H2O_IN_OIL;
      end
      FLT_ADDR[Q_REL_SAT][ADDR_W-1:1]: begin
        d.hit = 1'b1;
        d.idx = Q_REL_SAT;
      end
      FLT_ADDR[Q_MASS_FRAC][ADDR_W-1:1]: begin
        d.hit = 1'b1;
        d.idx = Q_MASS_FRAC;
      end
      default: begin
        d.hit = 1'b0;
      end
    endcase
    return d;
  endfunction

  // an integer is a single word, so only its exact address matches
  function automatic hpmr_dec_t hpmr_int_slot(input logic [ADDR_W-1:0] a);
    hpmr_dec_t d;
    d = '0;
    unique case (a)
      INT_ADDR[Q_RH]: begin
        d.hit = 1'b1;
        d.idx = Q_RH;
      end
      INT_ADDR[Q_TEMP]: begin
        d.hit = 1'b1;
        d.idx = Q_TEMP;
      end
      INT_ADDR[Q_DEWPT]: begin
        d.hit = 1'b1;
        d.idx = Q_DEWPT;
      end
      INT_ADDR[Q_DEW_FROST]: begin
        d.hit = 1'b1;
        d.idx = Q_DEW_FROST;
      end
      INT_ADDR[Q_DEW_FROST_1ATM]: begin
        d.hit = 1'b1;
        d.idx = Q_DEW_FROST_1ATM;
      end
      INT_ADDR[Q_DEWPT_1ATM]: begin
        d.hit = 1'b1;
        d.idx = Q_DEWPT_1ATM;
      end
      INT_ADDR[Q_ABS_HUM]: begin
        d.hit = 1'b1;
        d.idx = Q_ABS_HUM;
      end
      INT_ADDR[Q_MIX_RATIO]: begin
        d.hit = 1'b1;
        d.idx = Q_MIX_RATIO;
      end
      INT_ADDR[Q_WET_BULB]: begin
        d.hit = 1'b1;
        d.idx = Q_WET_BULB;
      end
      INT_ADDR[Q_H2O_CONC]: begin
        d.hit = 1'b1;
        d.idx = Q_H2O_CONC;
      end
      INT_ADDR[Q_VAPOUR_PRESS]: begin
        d.hit = 1'b1;
        d.idx = Q_VAPOUR_PRESS;
      end
      INT_ADDR[Q_SAT_PRESS]: begin
        d.hit = 1'b1;
        d.idx = Q_SAT_PRESS;
      end
      INT_ADDR[Q_ENTHALPY]: begin
        d.hit = 1'b1;
        d.idx = Q_ENTHALPY;
      end
      INT_ADDR[Q_WATER_ACT]: begin
        d.hit = 1'b1;
        d.idx = Q_WATER_ACT;
      end
      INT_ADDR[Q_DEWPT_DIFF]: begin
        d.hit = 1'b1;
        d.idx = Q_DEWPT_DIFF;
      end
      INT_ADDR[Q_ABS_HUM_NTP]: begin
        d.hit = 1'b1;
        d.idx = Q_ABS_HUM_NTP;
      end
      INT_ADDR[Q_H2O_IN_OIL]: begin
        d.hit = 1'b1;
        d.idx = Q_H2O_IN_OIL;
      end
      INT_ADDR[Q_REL_SAT]: begin
        d.hit = 1'b1;
        d.idx = Q_REL_SAT;
      end
      INT_ADDR[Q_MASS_FRAC]: begin
        d.hit = 1'b1;
        d.idx = Q_MASS_FRAC;
      end
      default: begin
        d.hit = 1'b0;
      end
    endcase
    return d;
  endfunction

  // an address in neither table is a miss, which the check state answers with an exception
  function automatic hpmr_dec_t hpmr_decode(input logic [ADDR_W-1:0] a);
    hpmr_dec_t d;
    d = hpmr_flt_slot(a);
    if (!d.hit) begin
      d = hpmr_int_slot(a);
    end
    return d;
  endfunction

  assign dec = hpmr_decode(r.cur);
  // missing data reads as the not-available pattern, never as an error
  assign pair = r.snap_ok[dec.idx] ? r.snap_flt[dec.idx] : FLOAT_NA;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.rsp_valid = 1'b0;
    next_r.rsp_exc = 1'b0;
    next_r.rsp_done = 1'b0;
    unique case (r.st)
      HPMR_IDLE: begin
        if (REQ_VALID) begin
          // the port carries zero-based bus addresses
          next_r.start = REQ_ADDR;
          next_r.cur = REQ_ADDR;
          next_r.total = REQ_COUNT;
          next_r.left = REQ_COUNT;
          // whole words are frozen at once, so no read mixes two updates
          for (int i = 0; i < NUM_QTY; i++) begin
            next_r.snap_flt[i] = MEAS_FLT[i*PAIR_W +: PAIR_W];
            next_r.snap_int[i] = MEAS_INT[i*WORD_W +: WORD_W];
          end
          next_r.snap_ok = MEAS_VALID;
          if (REQ_COUNT == '0) begin
            next_r.rsp_done = 1'b1;
          end else begin
            next_r.st = HPMR_CHECK;
          end
        end
      end
      HPMR_CHECK: begin
        // the whole range is checked before any word leaves
        // limitation: the check costs one cycle per word before the first word leaves
        if (!dec.hit) begin
          next_r.rsp_exc = 1'b1;
          next_r.rsp_done = 1'b1;
          next_r.st = HPMR_IDLE;
        end else if (r.left == CNT_W'(1)) begin
          next_r.cur = r.start;
          next_r.left = r.total;
          next_r.st = HPMR_SEND;
        end else begin
          next_r.cur = r.cur + ADDR_W'(1);
          next_r.left = r.left - CNT_W'(1);
        end
      end
      HPMR_SEND: begin
        next_r.rsp_valid = 1'b1;
        // a float half comes from the frozen pair, an integer straight from its slot
        if (dec.is_flt) begin
          next_r.rsp_data = dec.hi ? pair[PAIR_W-1:WORD_W] : pair[WORD_W-1:0];
        end else begin
          next_r.rsp_data = r.snap_ok[dec.idx] ? r.snap_int[dec.idx] : INT_NA;
        end
        next_r.cur = r.cur + ADDR_W'(1);
        next_r.left = r.left - CNT_W'(1);
        if (r.left == CNT_W'(1)) begin
          next_r.rsp_done = 1'b1;
          next_r.st = HPMR_IDLE;
        end
      end
      // the fourth state code is never entered; fall back to idle rather than hang
      default: begin
        next_r.st = HPMR_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // reset acts at once, its release is seen at the next rising edge
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // ready comes straight from state, so a new request may ride the done cycle
  assign REQ_READY = (r.st == HPMR_IDLE);
  assign RSP_VALID = r.rsp_valid;
  assign RSP_DATA = r.rsp_data;
  assign RSP_EXC = r.rsp_exc;
  assign RSP_DONE = r.rsp_done;

endmodule

`default_nettype wire

// ===== hpmr_regs_properties.sv
`default_nettype none
module hpmr_regs_properties #(parameter int CNT_W = 8) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RSTN,
  // measurements
  input wire logic [607:0] MEAS_FLT,
  input wire logic [303:0] MEAS_INT,
  input wire logic [18:0] MEAS_VALID,
  // request and answer
  input wire logic REQ_VALID,
  input wire logic [15:0] REQ_ADDR,
  input wire logic [CNT_W-1:0] REQ_COUNT,
  input wire logic REQ_READY,
  input wire logic RSP_VALID,
  input wire logic [15:0] RSP_DATA,
  input wire logic RSP_EXC,
  input wire logic RSP_DONE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  wire tk = REQ_VALID && REQ_READY;
  wire z = REQ_COUNT == 8'h00;
  wire n1 = REQ_COUNT == 8'h01;
  wire n2 = REQ_COUNT == 8'h02;
  a_exc_ends_xfer: assert property (
    RSP_EXC |-> RSP_DONE && !RSP_VALID) else $error("exc bad");
  a_gap_raises_exc: assert property (
    tk && REQ_ADDR == 16'h0004 && !z |-> ##2 RSP_EXC) else $error("gap no exc");
  a_zero_count_done: assert property (
    tk && z |-> ##1 RSP_DONE && !RSP_EXC && !RSP_VALID) else $error("zero count");
  a_busy_after_take: assert property (
    tk && !z |=> !REQ_READY) else $error("ready during transfer");
  a_flt_pair_order: assert property (
    tk && REQ_ADDR == 16'h0000 && n2 |-> ##4 RSP_VALID
    && RSP_DATA == $past(MEAS_FLT[15:0], 4)
    ##1 RSP_DONE && RSP_DATA == $past(MEAS_FLT[31:16], 5)) else $error("float pair");
  a_int_base_word: assert property (
    tk && REQ_ADDR == 16'h0100 && n1 && MEAS_VALID[0] |-> ##3 RSP_VALID && RSP_DONE
    && RSP_DATA == $past(MEAS_INT[15:0], 3)) else $error("int base");
  a_ntp_oil_words: assert property (
    tk && REQ_ADDR == 16'h0110 && n2 && MEAS_VALID[16:15] == 2'h3 |-> ##4
    RSP_VALID && RSP_DATA == $past(MEAS_INT[255:240], 4)
    ##1 RSP_DONE && RSP_DATA == $past(MEAS_INT[271:256], 5))
    else $error("ntp oil");
  a_int_na_word: assert property (
    tk && REQ_ADDR == 16'h0120 && n1 && !MEAS_VALID[18] |-> ##3 RSP_VALID && !RSP_EXC
    && RSP_DATA == 16'h8000) else $error("int na");
  a_flt_na_pair: assert property (
    tk && REQ_ADDR == 16'h0040 && n2 && !MEAS_VALID[18] |-> ##4 RSP_VALID
    && RSP_DATA == 16'h0000
    ##1 RSP_DONE && RSP_DATA == 16'h7FC0) else $error("float na");
  c_exc: cover property (RSP_EXC);
  c_pair: cover property (RSP_VALID ##1 RSP_VALID && RSP_DONE);
  c_zero: cover property (tk && z);
endmodule
bind hpmr_regs hpmr_regs_properties #(.CNT_W(CNT_W)) i_hpmr_regs_properties (.MCLK, .RSTN,
  .MEAS_FLT, .MEAS_INT, .MEAS_VALID, .REQ_VALID, .REQ_ADDR, .REQ_COUNT, .REQ_READY,
  .RSP_VALID, .RSP_DATA, .RSP_EXC, .RSP_DONE);
`default_nettype wire

// ===== tb_hpmr_regs.sv
`default_nettype none
module tb_hpmr_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rstn, req_valid, req_ready, rsp_valid, rsp_exc, rsp_done;
  logic [15:0] req_addr, rsp_data;
  logic [7:0] req_count;
  logic [607:0] meas_flt;
  logic [303:0] meas_int;
  logic [18:0] meas_valid;
  int fails = 0;
  int check_count = 0;
  hpmr_regs i_hpmr_regs (.MCLK(mclk), .RSTN(rstn), .MEAS_FLT(meas_flt), .MEAS_INT(meas_int),
    .MEAS_VALID(meas_valid), .REQ_VALID(req_valid), .REQ_ADDR(req_addr), .REQ_COUNT(req_count),
    .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_EXC(rsp_exc),
    .RSP_DONE(rsp_done));
  hpmr_master i_hpmr_master (.mclk, .req_valid, .req_addr, .req_count, .req_ready,
    .rsp_valid, .rsp_data, .rsp_exc, .rsp_done);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [15:0] fw(input int i, input bit hi);
    return hi ? {8'h40, 8'(i)} : {8'hA5, 8'(i)};
  endfunction
  function automatic logic [15:0] iw(input int i);
    return {8'h10, 8'(i)};
  endfunction
  function automatic logic [15:0] w(input int k);
    return i_hpmr_master.q[k];
  endfunction
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic rx(input logic [15:0] a, input logic [7:0] n, input logic [15:0] len,
    input logic ex);
    i_hpmr_master.rd(a, n);
    chk("len", 16'(i_hpmr_master.q.size()), len);
    chk("exc", 16'(i_hpmr_master.exc), 16'(ex));
    chk("done", 16'(i_hpmr_master.dn), 16'h0001);
    chk("ready", 16'(req_ready), 16'h0001);
  endtask
  task automatic t_float();
    for (int j = 0; j < 2; j++) begin
      rx(16'(2 * j), 8'h02, 16'h0002, 1'b0);
      chk("flt low", w(0), fw(j, 1'b0));
      chk("flt high", w(1), fw(j, 1'b1));
    end
    $display("test float done");
  endtask
  // the live value changes right after the take; the read must still show the frozen pair
  task automatic t_snap();
    fork
      rx(16'h0000, 8'h02, 16'h0002, 1'b0);
      begin
        @(negedge mclk);
        meas_flt[31:0] = ~meas_flt[31:0];
      end
    join
    chk("snap low", w(0), fw(0, 1'b0));
    chk("snap high", w(1), fw(0, 1'b1));
    meas_flt[31:0] = {fw(0, 1'b1), fw(0, 1'b0)};
    $display("test snapshot done");
  endtask
  task automatic t_int();
    rx(16'h0100, 8'h01, 16'h0001, 1'b0);
    chk("int base", w(0), iw(0));
    rx(16'h0110, 8'h02, 16'h0002, 1'b0);
    chk("int ntp", w(0), iw(15));
    chk("int oil", w(1), iw(16));
    $display("test int done");
  endtask
  task automatic t_na();
    meas_valid[18] = 1'b0;
    // register number minus one is the bus address
    rx(16'h0121 - 16'h0001, 8'h01, 16'h0001, 1'b0);
    chk("int na", w(0), 16'h8000);
    rx(16'h0041 - 16'h0001, 8'h02, 16'h0002, 1'b0);
    chk("flt na low", w(0), 16'h0000);
    chk("flt na high", w(1), 16'h7FC0);
    meas_valid[18] = 1'b1;
    $display("test na done");
  endtask
  task automatic t_exc();
    rx(16'h0004, 8'h01, 16'h0000, 1'b1);
    rx(16'h0022, 8'h03, 16'h0000, 1'b1);
    rx(16'h0000, 8'h00, 16'h0000, 1'b0);
    $display("test exc done");
  endtask
  initial begin
    rstn = 1'b0;
    meas_valid = '1;
    for (int i = 0; i < 19; i++) begin
      meas_flt[i*32+:32] = {fw(i, 1'b1), fw(i, 1'b0)};
      meas_int[i*16+:16] = iw(i);
    end
    repeat (12) @(negedge mclk);
    rstn = 1'b1;
    t_float();
    t_snap();
    t_int();
    t_na();
    t_exc();
    results();
  end
  // about thirty times the span the tests need
  initial begin
    #20000;
    fails++;
    results();
  end
endmodule
`default_nettype wire
